// ===== pkg/timekeeper_host_pkg.sv
// constants, types and helpers shared by the timekeeper host controller files
// assumes a 200 MHz REF_CLK; every pin timing below is derived from it
package timekeeper_host_pkg;

	// clock and pin timing in ns, with cycle counts derived from them
	localparam int CLK_NS          = 5;
	localparam int SCLK_HALF_NS    = 250;    // low or high time of the shift clock
	localparam int SETUP_NS        = 1000;   // enable high to first shift clock edge
	localparam int HOLD_NS         = 60;     // last shift clock edge to enable low
	localparam int GAP_NS          = 1000;   // enable inactive time between transfers
	localparam int STARTUP_S       = 3;      // oscillator settling after the halt bit clears
	localparam int CLK_HZ          = 1000000000 / CLK_NS;
	localparam logic [7:0] HALF_CNT  = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [7:0] SETUP_CNT = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam logic [7:0] HOLD_CNT  = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] GAP_CNT   = 8'((GAP_NS + CLK_NS - 1) / CLK_NS - 1);
	localparam int STARTUP_CYC     = STARTUP_S * CLK_HZ;

	// transfer lengths in shift clock pulses
	localparam logic [6:0] LAST_BIT_SINGLE = 7'h0f;   // 16 pulses
	localparam logic [6:0] LAST_BIT_BURST  = 7'h47;   // 72 pulses
	localparam logic [6:0] CMD_BITS        = 7'h08;

	// command byte layout
	localparam logic [7:0] CMD_SINGLE_BASE = 8'h80;
	localparam logic [7:0] CMD_BURST_BASE  = 8'hbe;
	localparam int         CMD_DIR_POS     = 0;
	localparam int         CMD_SEL_POS     = 1;

	// register selects on the device
	localparam logic [2:0] SEL_SECONDS     = 3'h0;
	localparam logic [2:0] SEL_MINUTES     = 3'h1;
	localparam logic [2:0] SEL_HOURS       = 3'h2;
	localparam logic [2:0] SEL_DATE        = 3'h3;
	localparam logic [2:0] SEL_MONTH       = 3'h4;
	localparam logic [2:0] SEL_DAY         = 3'h5;
	localparam logic [2:0] SEL_YEAR        = 3'h6;
	localparam logic [2:0] SEL_WRITE_LOCK  = 3'h7;

	// field positions inside device registers
	localparam int OSC_HALT_POS    = 7;   // seconds_with_halt
	localparam int HOUR_FMT_POS    = 7;   // hours_format: 1 = 12 hour
	localparam int MERIDIEM_POS    = 5;   // hours_format: pm, or tens bit in 24 hour
	localparam int WRITE_LOCK_POS  = 7;   // write_lock
	localparam logic [7:0] INIT_DATA = 8'h00;   // lock open, halt clear

	// one request from the user side
	typedef struct packed {
		logic       rd;      // 1 read, 0 write
		logic       burst;   // all eight registers
		logic [2:0] sel;     // reg_select_bits, single mode only
	} cmd_type;

	// one byte returned by a read
	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] data;
	} rd_word_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_LOAD  = 3'b010,
		ST_LOW   = 3'b011,
		ST_HIGH  = 3'b100,
		ST_HOLD  = 3'b101,
		ST_GAP   = 3'b110
	} state_type;

	// build the command byte; the shape can never hit the test pattern
	function automatic logic [7:0] make_cmd(input cmd_type c);
		logic [7:0] b;
		b = c.burst ? CMD_BURST_BASE : (CMD_SINGLE_BASE | {4'h0, c.sel, 1'b0});
		b[CMD_DIR_POS] = c.rd;
		return b;
	endfunction : make_cmd

endpackage : timekeeper_host_pkg

// ===== src/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// honest full and empty from the occupancy count
	assign in_ready  = count_reg != (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	// storage has no reset; only pointers and the count need a defined value
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// pointers wrap; depth is expected to be a power of two
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : byte_fifo

// ===== src/timekeeper_host.sv
// host controller for a three-wire serial timekeeper
// assumes REF_CLK at 200 MHz and a device that keeps its own side of the link
//
// How it works
// - command bytes are built so the factory test pattern never goes out
// - at startup host programs the lock register first, before writing seconds
// - host raises transfer enable to start each transfer
// - host presents each bit before the rising shift clock edge
// - single write is command then eight data bits, extras ignored
// - every field goes least significant bit first
// - each transfer opens with an eight bit command byte
// - host returns transfer enable low after every transfer
// - single transfer is 16 pulses, burst is 72 pulses
// - at start host clears lock and halt, then waits three seconds
`timescale 1ns/100ps
module timekeeper_host
	import timekeeper_host_pkg::*;
#(
	parameter int STARTUP_WAIT = STARTUP_CYC
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	// user command port
	input  wire logic        CMD_VALID,
	output logic             CMD_READY,
	input  wire cmd_type     CMD,
	// user write data
	input  wire logic        WR_VALID,
	output logic             WR_READY,
	input  wire logic [7:0]  WR_DATA,
	// user read data
	output logic             RD_VALID,
	output rd_word_type      RD_WORD,
	// status
	output logic             INIT_DONE,
	// device pins
	output logic             TRANSFER_ENABLE,
	output logic             SHIFT_CLK,
	output logic             DATA_O,
	output logic             DATA_OE,
	input  wire logic        DATA_I
);

	state_type   state_reg, state_next;
	cmd_type     cmd_reg, cmd_next;
	logic        internal_reg, internal_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic [6:0]  bit_reg, bit_next;
	logic [7:0]  shreg_reg, shreg_next;
	logic        ce_reg, ce_next;
	logic        sclk_reg, sclk_next;
	logic        oe_reg, oe_next;
	logic        rd_valid_reg, rd_valid_next;
	rd_word_type rd_word_reg, rd_word_next;
	logic [1:0]  step_reg;
	logic [31:0] wait_reg;
	logic        din_meta_reg;
	logic        din_sync_reg;

	logic        fifo_valid;
	logic [7:0]  fifo_data;
	logic        fifo_pop;

	// write data passes a small fifo; the shifter drains one byte per eight data pulses
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (4)
	) u_wr_fifo (
		.clk       (REF_CLK),
		.rst       (RST),
		.in_valid  (WR_VALID),
		.in_ready  (WR_READY),
		.in_data   (WR_DATA),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// decode of the current transfer position
	wire       is_read    = cmd_reg.rd;
	wire       data_phase = bit_reg >= CMD_BITS;
	wire       byte_start = bit_reg[2:0] == 3'h0;
	wire       sampling   = is_read && data_phase;
	wire       half_done  = cnt_reg == 8'h00;
	wire       last_bit   = bit_reg == (cmd_reg.burst ? LAST_BIT_BURST : LAST_BIT_SINGLE);
	wire       need_fifo  = state_reg == ST_LOAD && data_phase && byte_start
	                        && !is_read && !internal_reg;
	wire       load_stall = need_fifo && !fifo_valid;
	wire [2:0] byte_no    = 3'(bit_reg[5:3] - 3'h1);
	wire       init_go    = state_reg == ST_IDLE && step_reg < 2'h2;
	wire [7:0] sampled    = {din_sync_reg, shreg_reg[7:1]};

	// startup writes lock first, then seconds with the halt bit clear
	wire cmd_type init_cmd = '{rd: 1'b0, burst: 1'b0,
	                           sel: (step_reg == 2'h0) ? SEL_WRITE_LOCK : SEL_SECONDS};

	assign fifo_pop  = need_fifo;
	assign CMD_READY = state_reg == ST_IDLE && step_reg == 2'h3;
	assign INIT_DONE = step_reg == 2'h3;

	// transfer sequencer
	always_comb begin
		state_next    = state_reg;
		cmd_next      = cmd_reg;
		internal_next = internal_reg;
		cnt_next      = half_done ? cnt_reg : cnt_reg - 8'h01;
		bit_next      = bit_reg;
		shreg_next    = shreg_reg;
		ce_next       = ce_reg;
		sclk_next     = sclk_reg;
		oe_next       = oe_reg;
		rd_valid_next = 1'b0;
		rd_word_next  = rd_word_reg;
		case (state_reg)
			ST_IDLE: begin
				if (init_go) begin
					cmd_next      = init_cmd;
					internal_next = 1'b1;
					ce_next       = 1'b1;
					cnt_next      = SETUP_CNT;
					state_next    = ST_SETUP;
				end else if (CMD_VALID && CMD_READY) begin
					cmd_next      = CMD;
					internal_next = 1'b0;
					ce_next       = 1'b1;
					cnt_next      = SETUP_CNT;
					state_next    = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (half_done) begin
					bit_next   = 7'h00;
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// a missing write byte holds the clock low until it arrives
				if (!load_stall) begin
					if (bit_reg == 7'h00) begin
						shreg_next = make_cmd(cmd_reg);
					end else if (data_phase && byte_start && !is_read) begin
						shreg_next = internal_reg ? INIT_DATA : fifo_data;
					end
					oe_next    = !sampling;
					cnt_next   = HALF_CNT;
					state_next = ST_LOW;
				end
			end
			ST_LOW: begin
				if (half_done) begin
					if (sampling) begin
						shreg_next = sampled;
						if (bit_reg[2:0] == 3'h7) begin
							rd_valid_next     = 1'b1;
							rd_word_next.data = sampled;
							rd_word_next.idx  = cmd_reg.burst ? byte_no : cmd_reg.sel;
						end
					end
					sclk_next  = 1'b1;
					cnt_next   = HALF_CNT;
					state_next = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (half_done) begin
					sclk_next = 1'b0;
					if (!sampling) begin
						shreg_next = {1'b0, shreg_reg[7:1]};
					end
					if (last_bit) begin
						// stopping here keeps extra clocks from resending data
						cnt_next   = HOLD_CNT;
						state_next = ST_HOLD;
					end else begin
						bit_next   = bit_reg + 7'h01;
						state_next = ST_LOAD;
					end
				end
			end
			ST_HOLD: begin
				if (half_done) begin
					ce_next    = 1'b0;
					oe_next    = 1'b0;
					cnt_next   = GAP_CNT;
					state_next = ST_GAP;
				end
			end
			ST_GAP: begin
				if (half_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				ce_next    = 1'b0;
				sclk_next  = 1'b0;
				oe_next    = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_reg    <= ST_IDLE;
			cmd_reg      <= '0;
			internal_reg <= 1'b0;
			cnt_reg      <= 8'h00;
			bit_reg      <= 7'h00;
		end else begin
			state_reg    <= state_next;
			cmd_reg      <= cmd_next;
			internal_reg <= internal_next;
			cnt_reg      <= cnt_next;
			bit_reg      <= bit_next;
		end
	end

	// pin and read result registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			shreg_reg    <= 8'h00;
			ce_reg       <= 1'b0;
			sclk_reg     <= 1'b0;
			oe_reg       <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_word_reg  <= '0;
		end else begin
			shreg_reg    <= shreg_next;
			ce_reg       <= ce_next;
			sclk_reg     <= sclk_next;
			oe_reg       <= oe_next;
			rd_valid_reg <= rd_valid_next;
			rd_word_reg  <= rd_word_next;
		end
	end

	// startup: two writes, then wait for the oscillator to settle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			step_reg <= 2'h0;
			wait_reg <= 32'h0000_0000;
		end else if (init_go) begin
			step_reg <= step_reg + 2'h1;
			wait_reg <= 32'(STARTUP_WAIT);
		end else if (step_reg == 2'h2 && state_reg == ST_IDLE) begin
			wait_reg <= (wait_reg == 32'h0000_0000) ? wait_reg : wait_reg - 32'h0000_0001;
			step_reg <= (wait_reg == 32'h0000_0000) ? 2'h3 : step_reg;
		end
	end

	// data pin crosses into REF_CLK through two flops
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
		end else begin
			din_meta_reg <= DATA_I;
			din_sync_reg <= din_meta_reg;
		end
	end

	assign TRANSFER_ENABLE = ce_reg;
	assign SHIFT_CLK       = sclk_reg;
	assign DATA_O          = shreg_reg[0];   // low bit leads, field goes out lsb first
	assign DATA_OE         = oe_reg;
	assign RD_VALID        = rd_valid_reg;
	assign RD_WORD         = rd_word_reg;

endmodule : timekeeper_host

// ===== verif/timekeeper_host_asserts.sv
// concurrent checks on the pins and user port of the timekeeper host
// assumes it is bound to timekeeper_host and sees only its ports
`timescale 1ns/100ps
module timekeeper_host_asserts (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// user side
	input wire logic CMD_VALID,
	input wire logic CMD_READY,
	input wire logic RD_VALID,
	input wire logic INIT_DONE,
	// device pins
	input wire logic TRANSFER_ENABLE,
	input wire logic SHIFT_CLK,
	input wire logic DATA_O,
	input wire logic DATA_OE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	logic       sclk_reg;
	logic [6:0] pulse_reg;
	logic       rise;

	// rising shift clock edges counted per transfer, cleared while enable is low
	assign rise = SHIFT_CLK && !sclk_reg;
	always_ff @(posedge REF_CLK) begin
		sclk_reg  <= RST ? 1'b0 : SHIFT_CLK;
		pulse_reg <= (RST || !TRANSFER_ENABLE) ? 7'h00 : pulse_reg + 7'(rise);
	end

	sequence s_take;
		CMD_VALID && CMD_READY;
	endsequence
	sequence s_open;
		TRANSFER_ENABLE && !SHIFT_CLK;
	endsequence
	sequence s_settle;
		!SHIFT_CLK [*8];
	endsequence

	open_on_take_a:
		assert property (s_take |=> s_open ##1 s_settle) else $error("enable not opened");
	setup_low_a:
		assert property ($rose(TRANSFER_ENABLE) |-> s_settle) else $error("clock too soon");
	idle_pins_a:
		assert property (!TRANSFER_ENABLE |-> !SHIFT_CLK && !DATA_OE) else $error("idle pins");
	data_held_a:
		assert property (SHIFT_CLK && DATA_OE |-> $stable(DATA_O)) else $error("data moved");
	pulse_total_a:
		assert property ($fell(TRANSFER_ENABLE) |-> pulse_reg == 7'h10 || pulse_reg == 7'h48)
			else $error("wrong pulse count");
	// the byte is handed over as the clock rises for its eighth data bit
	byte_done_a:
		assert property (RD_VALID |-> rise && pulse_reg[2:0] == 3'h7 && pulse_reg >= 7'h0f)
			else $error("read byte misplaced");
	read_released_a:
		assert property (RD_VALID |-> !DATA_OE && !$past(DATA_OE)) else $error("pin driven");
	busy_not_ready_a:
		assert property (TRANSFER_ENABLE |-> !CMD_READY) else $error("ready while busy");
	init_first_a:
		assert property (CMD_READY |-> INIT_DONE) else $error("ready before init");
endmodule : timekeeper_host_asserts

bind timekeeper_host timekeeper_host_asserts u_chk (
	.REF_CLK(REF_CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
	.RD_VALID(RD_VALID), .INIT_DONE(INIT_DONE), .TRANSFER_ENABLE(TRANSFER_ENABLE),
	.SHIFT_CLK(SHIFT_CLK), .DATA_O(DATA_O), .DATA_OE(DATA_OE)
);

// ===== verif/timekeeper_dev_model.sv
// behavioural serial timekeeper slave: eight registers, lock and burst
// assumes the bench resolves the shared data wire; only seconds tick, no calendar carry
`timescale 1ns/100ps
module timekeeper_dev_model (
	// pins seen from the device
	input  wire logic ce,
	input  wire logic sclk,
	input  wire logic dio,
	output logic      dq_o,
	output logic      dq_oe,
	// set once a factory test command arrives
	output logic      bad_cmd
);
	logic [7:0] regs [8];
	logic [7:0] cmd;
	logic [7:0] sh;
	int         n;

	// power up halted and locked so the host start sequence matters
	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
		regs[0] = 8'h80;
		regs[7] = 8'h80;
		{cmd, sh, n, dq_o, dq_oe, bad_cmd} = '0;
	end

	// lock only through single writes, others only while unlocked
	task automatic store(input logic [2:0] a);
		if (a == 3'h7) begin
			if (!cmd[5]) regs[7] = {sh[7], 7'h00};
		end else if (!regs[7][7]) regs[a] = sh;
	endtask : store

	// seconds tick once a second while running; a short run never reaches it
	always #1000000000 if (!regs[0][7]) begin
		if (regs[0][6:0] == 7'h59) regs[0] = 8'h00;
		else if (regs[0][3:0] == 4'h9) regs[0] = {1'b0, regs[0][6:4] + 3'h1, 4'h0};
		else regs[0] = regs[0] + 8'h01;
	end

	// enable low aborts and floats the pin
	always @(negedge ce) begin
		n = 0;
		dq_oe = 1'b0;
	end

	// bits taken on rising edges, lsb first; extra write clocks ignored
	always @(posedge sclk) if (ce) begin
		if (n < 8) cmd[n] = dio;
		else if (!cmd[0] && (cmd[5] ? n < 72 : n < 16)) begin
			sh[n % 8] = dio;
			if (n % 8 == 7) store(cmd[5] ? 3'((n - 8) / 8) : cmd[3:1]);
		end
		if (n == 7 && cmd[7:4] == 4'h9 && cmd[0]) bad_cmd = 1'b1;
		n++;
	end

	// output after falling edges, wrapping while enable stays high
	always @(negedge sclk) if (ce && n >= 8 && cmd[0]) begin
		dq_oe <= #40 1'b1;
		dq_o  <= #100 regs[cmd[5] ? 3'((n - 8) / 8 % 8) : cmd[3:1]][(n - 8) % 8];
	end
endmodule : timekeeper_dev_model

// ===== verif/testbench.sv
// self-checking bench: host controller against the device model
// assumes the checker is bound by its own file; short startup wait
`timescale 1ns/100ps
module testbench
	import timekeeper_host_pkg::*;
;
	logic        ref_clk = 0, rst = 1, cmd_valid = 0, wr_valid = 0, flt = 0;
	logic [7:0]  wr_data = 8'h00;
	cmd_type     cmd = '0;
	logic        cmd_ready, wr_ready, rd_valid, init_done, te, sclk, d_o, d_oe;
	logic        m_o, m_oe, bad;
	rd_word_type rd_word;
	int          errors = 0, n_compared = 0, pulses = 0, last_pulses = 0;
	logic [7:0]  vals [7] = '{8'h59, 8'h07, 8'ha5, 8'h31, 8'h12, 8'h06, 8'h99};
	logic [7:0]  bv [8] = '{8'hb0, 8'h45, 8'h23, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80};
	wire         dio = d_oe ? d_o : (m_oe ? m_o : flt); // released wire toggles

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) flt <= ~flt;
	// pulses per transfer, latched when enable drops
	always @(posedge sclk) pulses++;
	always @(negedge te) begin
		last_pulses = pulses;
		pulses = 0;
	end

	timekeeper_host #(.STARTUP_WAIT(100)) u_dut (
		.REF_CLK(ref_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD(cmd), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data),
		.RD_VALID(rd_valid), .RD_WORD(rd_word), .INIT_DONE(init_done),
		.TRANSFER_ENABLE(te), .SHIFT_CLK(sclk), .DATA_O(d_o), .DATA_OE(d_oe), .DATA_I(dio));
	timekeeper_dev_model u_dev (.ce(te), .sclk(sclk), .dio(dio), .dq_o(m_o), .dq_oe(m_oe),
		.bad_cmd(bad));

	task automatic results;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wait_ready;
		int i;
		for (i = 0; i < 30000 && cmd_ready !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 30000) begin
			errors++;
			results();
		end
	endtask : wait_ready

	task automatic xfer(input logic rd, input logic burst, input logic [2:0] sel);
		wait_ready();
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= '{rd, burst, sel};
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		// let the take reach the sequencer so the next ready test is not stale
		@(posedge ref_clk);
	endtask : xfer

	task automatic wait_rd(input rd_word_type exp);
		int i;
		for (i = 0; i < 30000; i++) begin
			@(posedge ref_clk);
			#1;
			if (rd_valid === 1'b1) break;
		end
		if (i == 30000) begin
			errors++;
			results();
		end
		check(rd_word, exp);
	endtask : wait_rd

	task automatic push(input logic [7:0] b);
		int i;
		@(posedge ref_clk);
		wr_valid <= 1'b1;
		wr_data <= b;
		for (i = 0; i < 30000; i++) begin
			@(posedge ref_clk);
			if (wr_ready === 1'b1) break;
		end
		wr_valid <= 1'b0;
		if (i == 30000) begin
			errors++;
			results();
		end
	endtask : push

	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		wait_ready(); check({10'h000, init_done}, 11'h001);
		xfer(1, 0, 7); wait_rd({3'h7, 8'h00});
		xfer(1, 0, 0); wait_rd({3'h0, 8'h00});
		for (int i = 0; i < 4; i++) push(vals[i]);
		@(posedge ref_clk); #1; check({10'h000, wr_ready}, 11'h000);
		for (int i = 0; i < 7; i++) begin
			if (i > 3 && i < 6) push(vals[i]);
			xfer(0, 0, 3'(i));
			if (i == 6) begin
				// nothing queued: host must sit at the first data bit, clock low
				repeat (1500) @(posedge ref_clk);
				#1;
				check({9'h000, te, sclk}, 11'h002);
				push(vals[6]);
			end
		end
		for (int i = 0; i < 7; i++) begin
			xfer(1, 0, 3'(i)); wait_rd({3'(i), vals[i]});
		end
		wait_ready(); check(11'(last_pulses), 11'h010);
		xfer(0, 1, 0);
		for (int i = 0; i < 8; i++) push(bv[i]);
		xfer(1, 1, 0);
		for (int i = 0; i < 8; i++) begin
			wait_rd({3'(i), i == 7 ? 8'h00 : bv[i]});
		end
		wait_ready(); check(11'(last_pulses), 11'h048);
		push(8'h80); xfer(0, 0, 7);
		push(8'h11); xfer(0, 0, 1);
		xfer(1, 0, 1); wait_rd({3'h1, bv[1]});
		xfer(1, 0, 7); wait_rd({3'h7, 8'h80});
		wait_ready(); check({10'h000, bad}, 11'h000);
		results();
	end
endmodule : testbench
